// ### bench/isf_core_tb_top.sv
`timescale 1ns/1ps
`include "isf_params.svh"
module isf_core_tb_top;
   import isf_pkg::*;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic hw_rel, rel_dis, mod_on, freq_hi, chop, flim, errc, crun, ttrig, wden, erel, irq, se;
   logic [15:0] dc;
   logic [7:0] disp;
   isf_cond_s cond;
   isf_stat_s sw;
   int err_total, n_tests;
   // short base-block time keeps the run brief
   isf_core #(.VAL_W(16), .BB_CYC(8)) u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .hardware_release_input(hw_rel),
      .release_disable_input(rel_dis), .cond(cond), .modulation_on(mod_on),
      .sw_freq_above_rated(freq_hi), .dc_link_voltage(dc), .brake_chopper_transistor(chop),
      .switch_freq_limit(flim), .error_condition(errc), .constant_run_condition(crun),
      .timer_trigger(ttrig), .watchdog_enable(wden), .effective_release(erel),
      .drive_state_display(disp), .drive_status_word(sw), .irq(irq));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic chk_bit(input string nm, input logic e, input logic s);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %0b seen %0b", nm, e, s);
      end
   endtask
   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %08h seen %08h", nm, e, s);
      end
   endtask
   // bus cycle waits for pready without assuming a latency
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rv = prdata;
      se = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 50) chk_bit("pready", 1'b1, 1'b0);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic settle();
      repeat (3) @(posedge pclk);
   endtask
   task automatic rst(input int n);
      presetn <= 1'b0; clk_en <= 1'b1; psel <= 1'b0; penable <= 1'b0; pwrite <= 1'b0;
      paddr <= 12'h000; pwdata <= 32'h0; hw_rel <= 1'b1; rel_dis <= 1'b0; cond <= '0;
      mod_on <= 1'b0; freq_hi <= 1'b0; dc <= 16'h0000;
      repeat (n) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask
   task automatic t_regs();
      rst(2);
      chk_bit("wd_after_reset", 1'b1, wden);
      apb(1'b0, `ISF_ADDR_FLAGS, 32'h0);
      chk_word("flags_reset", 32'h0000_0000, rv);
      wr(`ISF_ADDR_FLAGS, 32'hFFFF_FFFF);
      apb(1'b0, `ISF_ADDR_FLAGS, 32'h0);
      chk_word("flags_rw", 32'h0000_7FFF, rv);
      apb(1'b0, 12'h0FC, 32'h0);
      chk_bit("unmapped_err", 1'b1, se);
      chk_word("unmapped_rd", 32'h0, rv);
      $display("test regs done");
   endtask
   task automatic t_chop();
      rst(2);
      wr(`ISF_ADDR_THRESH, 32'd100);
      dc <= 16'd200;
      settle();
      chk_bit("chop_default", 1'b0, chop);
      wr(`ISF_ADDR_FLAGS, 32'h0000_0001);
      settle();
      chk_bit("chop_nop_bit0", 1'b1, chop);
      dc <= 16'd50;
      settle();
      chk_bit("chop_below", 1'b0, chop);
      dc <= 16'd200;
      hw_rel <= 1'b0;
      settle();
      chk_bit("chop_hw_open", 1'b0, chop);
      hw_rel <= 1'b1;
      wr(`ISF_ADDR_FLAGS, 32'h0000_0020);
      wr(`ISF_ADDR_CTRL, 32'h0000_0003);
      settle();
      chk_bit("chop_sw_nop", 1'b1, chop);
      $display("test chopper done");
   endtask
   task automatic t_derate();
      rst(2);
      freq_hi <= 1'b1;
      settle();
      chk_bit("flim_off", 1'b0, flim);
      wr(`ISF_ADDR_FLAGS, 32'h0000_0040);
      settle();
      chk_bit("flim_on", 1'b1, flim);
      // low enable must freeze the registered outputs
      clk_en <= 1'b0;
      freq_hi <= 1'b0;
      settle();
      chk_bit("flim_frozen", 1'b1, flim);
      clk_en <= 1'b1;
      $display("test derate done");
   endtask
   task automatic t_uv();
      rst(2);
      wr(`ISF_ADDR_FLAGS, 32'h0000_0080);
      cond.uv <= 1'b1;
      settle();
      chk_bit("uv_masked_cond", 1'b0, errc);
      chk_bit("uv_masked_bit", 1'b0, sw.error_bit);
      rst(2);
      cond.uv <= 1'b1;
      settle();
      chk_bit("uv_error", 1'b1, errc);
      $display("test undervoltage done");
   endtask
   task automatic t_warn();
      rst(2);
      cond.warn <= 1'b1;
      settle();
      chk_bit("warn_plain", 1'b0, errc);
      rst(2);
      wr(`ISF_ADDR_FLAGS, 32'h0000_0400);
      cond.warn <= 1'b1;
      settle();
      chk_bit("warn_cond", 1'b1, errc);
      chk_bit("warn_bit", 1'b1, sw.error_bit);
      chk_bit("irq_masked", 1'b0, irq);
      apb(1'b0, `ISF_ADDR_IRQ_STAT, 32'h0);
      chk_bit("irq_stat", 1'b1, rv[0]);
      wr(`ISF_ADDR_IRQ_EN, 32'h0000_0001);
      settle();
      chk_bit("irq_on", 1'b1, irq);
      wr(`ISF_ADDR_IRQ_CLR, 32'h0000_0001);
      settle();
      chk_bit("irq_clr", 1'b0, irq);
      $display("test warning done");
   endtask
   task automatic t_bbl();
      rst(2);
      wr(`ISF_ADDR_FLAGS, 32'h0000_0100);
      cond.fault <= 1'b1;
      settle();
      chk_word("disp_hidden", {24'h0, `ISF_DISP_ERR}, {24'h0, disp});
      rst(2);
      cond.fault <= 1'b1;
      settle();
      chk_word("disp_bbl", {24'h0, `ISF_DISP_BBL}, {24'h0, disp});
      wr(`ISF_ADDR_CTRL, 32'h0000_0004);
      cond.fault <= 1'b0;
      repeat (20) @(posedge pclk);
      chk_word("disp_no_early_rst", {24'h0, `ISF_DISP_ERR}, {24'h0, disp});
      wr(`ISF_ADDR_CTRL, 32'h0000_0004);
      settle();
      chk_word("disp_after_rst", {24'h0, `ISF_DISP_NOP}, {24'h0, disp});
      chk_bit("err_after_rst", 1'b0, errc);
      $display("test base block done");
   endtask
   task automatic t_wd();
      rst(2);
      // a bus-driven release expects both watchdogs on by default
      rel_dis <= 1'b1;
      settle();
      chk_bit("wd_kept", 1'b1, wden);
      wr(`ISF_ADDR_FLAGS, 32'h0000_0800);
      // software release selected but not given: only the terminal counts
      wr(`ISF_ADDR_CTRL, 32'h0000_0002);
      settle();
      chk_bit("wd_off", 1'b0, wden);
      chk_bit("rel_hw_on", 1'b1, erel);
      hw_rel <= 1'b0;
      settle();
      chk_bit("rel_hw_off", 1'b0, erel);
      $display("test watchdog done");
   endtask
   task automatic t_eq();
      rst(2);
      wr(`ISF_ADDR_FLAGS, 32'h0000_2000);
      wr(`ISF_ADDR_ACTUAL, 32'd5);
      wr(`ISF_ADDR_SETVAL, 32'd5);
      settle();
      chk_bit("eq_status", 1'b1, sw.equal_bit);
      chk_bit("eq_cond20", 1'b1, crun);
      wr(`ISF_ADDR_SETVAL, 32'd6);
      settle();
      chk_bit("neq_status", 1'b0, sw.equal_bit);
      chk_bit("neq_cond20", 1'b0, crun);
      $display("test equality done");
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // generous bound: the whole sequence needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      results();
   end
   initial begin
      err_total = 0;
      n_tests = 0;
      rst(16);
      t_regs();
      t_chop();
      t_derate();
      t_uv();
      t_warn();
      t_wd();
      t_bbl();
      t_eq();
      results();
   end
endmodule

// ### core/isf_core.sv
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "isf_params.svh"
// Functional notes
// (R1) bit 5 with software release permits chopper in no-operation state
// (R2) open hardware release switches chopper off immediately
// (R3) bit 6 limits switching frequency to rated value
// (R4) bit 7 hides undervoltage error without direction or release
// (R5) bit 8 hides base-block state, shows the underlying cause
// (R6) error reset refused until base-block time expired
// (R7) bit 10 makes warnings set error bit and error condition
// (R8) bit 11 lets release-disable input disable both watchdogs
// (R9) bit 12 resets only while actual value below hysteresis
// (R10) bit 13 runs equality check continuously, even modulation off
// (R11) equality result feeds status, timer conditions and condition 20
// (R12) chopper off while modulation off unless a state flag enables
// (R13) permitted chopper turns on above DC-link threshold
// (R14) release-disable input leaves only hardware release effective
// (R15) disabled watchdogs with auto-restart clear the watchdog fault
// (R16) bus controller should enable both watchdogs
// (R17) bit 0 also permits chopper in no-operation state
// (R18) reserved bits stored and read back without effect
module isf_core
   import isf_pkg::*;
#(
   parameter int VAL_W   = 16,
   parameter int BB_CYC  = `ISF_BB_TIME_US * `ISF_CLK_MHZ
) (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              clk_en,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   // drive inputs
   input  wire logic              hardware_release_input,
   input  wire logic              release_disable_input,
   input  wire isf_cond_s         cond,
   input  wire logic              modulation_on,
   input  wire logic              sw_freq_above_rated,
   input  wire logic [VAL_W-1:0]  dc_link_voltage,
   // drive outputs
   output logic                   brake_chopper_transistor,
   output logic                   switch_freq_limit,
   output logic                   error_condition,
   output logic                   constant_run_condition,
   output logic                   timer_trigger,
   output logic                   watchdog_enable,
   output logic                   effective_release,
   output logic [7:0]             drive_state_display,
   output isf_stat_s              drive_status_word,
   output logic                   irq
);
   localparam int CNT_W = $clog2(BB_CYC + 1);

   logic [14:0]       flags_q, flags_d;
   logic [3:0]        ctrl_q, ctrl_d;
   logic [VAL_W-1:0]  thr_q, thr_d, act_q, act_d, set_q, set_d, hys_q, hys_d;
   logic [`ISF_IRQ_W-1:0] ist_q, ist_d, ien_q, ien_d;
   logic [CNT_W-1:0]  bb_q, bb_d;
   isf_state_e        st_q, st_d;
   logic              ready_q, ready_d, slverr_q, slverr_d;
   logic [31:0]       rdata_q, rdata_d;
   logic              chop_q, chop_d, frq_q, frq_d, err_q, err_d, cr_q, cr_d;
   logic              tmr_q, tmr_d, wd_q, wd_d, rel_q, rel_d, irq_q, irq_d;
   logic [7:0]        disp_q, disp_d;
   isf_stat_s         sw_q, sw_d;
   logic              eq_prev_q, eq_prev_d;

   logic wr, rd, rel_eff, chop_perm, err_now, equal, eq_chk, reset_ok, wd_off, rst_go;
   logic [VAL_W-1:0] act_mag;

   always_comb begin
      wr = psel && penable && pwrite && !ready_q;
      rd = psel && penable && !pwrite && !ready_q;
      // (R14) hardware release only
      rel_eff = release_disable_input ? hardware_release_input
              : (hardware_release_input &&
                 (ctrl_q[`ISF_C_SW_SEL] ? ctrl_q[`ISF_C_SW_REL] : 1'b1));
      // (R8) watchdogs off by input
      wd_off = flags_q[`ISF_B_WD_OFF] && release_disable_input;
      // (R4) undervoltage filter
      err_now = cond.fault
              || (cond.uv && !(flags_q[`ISF_B_UV_NOERR] && (!cond.dir_ok || !rel_eff)))
              // (R15) watchdog fault cleared when disabled
              || ((cond.wd_bus || cond.wd_time) && !(wd_off && ctrl_q[`ISF_C_WD_AUTO]))
              // (R7) warning counts as error
              || (cond.warn && flags_q[`ISF_B_WARN_ERR]);
      act_mag = act_q[VAL_W-1] ? VAL_W'(-act_q) : act_q;
      equal = (act_q == set_q);
      // (R10) continuous equality check
      eq_chk = equal && (flags_q[`ISF_B_CHK_CONT] || (modulation_on && !cond.search));
      // (R9) reset near zero only
      reset_ok = !flags_q[`ISF_B_RST_AT0] || (act_mag < hys_q);
      // (R12) chopper state permits, (R1) (R17)
      chop_perm = modulation_on
                || (st_q == ISF_ST_NOP && flags_q[`ISF_B_CHOP_NOP])
                || (st_q == ISF_ST_NOP && flags_q[`ISF_B_CHOP_SWNOP] && ctrl_q[`ISF_C_SW_SEL]);
      rst_go = ctrl_q[`ISF_C_RST_REQ] && reset_ok;
   end

   always_comb begin
      flags_d = flags_q;
      ctrl_d = ctrl_q;
      thr_d = thr_q; act_d = act_q; set_d = set_q; hys_d = hys_q;
      ien_d = ien_q;
      ready_d = psel && penable && !ready_q;
      slverr_d = 1'b0;
      rdata_d = rdata_q;
      if (rst_go || st_q != ISF_ST_ERROR)
         ctrl_d[`ISF_C_RST_REQ] = 1'b0;
      if (wr) begin
         case (paddr)
            // (R18) all bits stored
            `ISF_ADDR_FLAGS:   flags_d = pwdata[14:0];
            `ISF_ADDR_CTRL:    ctrl_d = pwdata[3:0];
            `ISF_ADDR_IRQ_EN:  ien_d = pwdata[`ISF_IRQ_W-1:0];
            `ISF_ADDR_IRQ_CLR: ;
            `ISF_ADDR_THRESH:  thr_d = pwdata[VAL_W-1:0];
            `ISF_ADDR_ACTUAL:  act_d = pwdata[VAL_W-1:0];
            `ISF_ADDR_SETVAL:  set_d = pwdata[VAL_W-1:0];
            `ISF_ADDR_HYST:    hys_d = pwdata[VAL_W-1:0];
            default:           slverr_d = 1'b1;
         endcase
      end
      if (rd) begin
         rdata_d = 32'h0000_0000;
         case (paddr)
            `ISF_ADDR_FLAGS:    rdata_d[14:0] = flags_q;
            `ISF_ADDR_CTRL:     rdata_d[3:0] = ctrl_q;
            `ISF_ADDR_STATUS:   rdata_d[4:0] = sw_q;
            `ISF_ADDR_IRQ_STAT: rdata_d[`ISF_IRQ_W-1:0] = ist_q;
            `ISF_ADDR_IRQ_EN:   rdata_d[`ISF_IRQ_W-1:0] = ien_q;
            `ISF_ADDR_THRESH:   rdata_d[VAL_W-1:0] = thr_q;
            `ISF_ADDR_ACTUAL:   rdata_d[VAL_W-1:0] = act_q;
            `ISF_ADDR_SETVAL:   rdata_d[VAL_W-1:0] = set_q;
            `ISF_ADDR_HYST:     rdata_d[VAL_W-1:0] = hys_q;
            default:            slverr_d = 1'b1;
         endcase
      end
   end

   // drive state and base-block timer
   always_comb begin
      st_d = st_q;
      bb_d = (bb_q != '0) ? bb_q - CNT_W'(1) : bb_q;
      case (st_q)
         ISF_ST_NOP: begin
            if (err_now) begin
               st_d = ISF_ST_BBLOCK;
               bb_d = CNT_W'(BB_CYC);
            end else if (modulation_on)
               st_d = ISF_ST_RUN;
         end
         ISF_ST_RUN: begin
            if (err_now) begin
               st_d = ISF_ST_BBLOCK;
               bb_d = CNT_W'(BB_CYC);
            end else if (!modulation_on)
               st_d = ISF_ST_NOP;
         end
         ISF_ST_BBLOCK: begin
            if (bb_q == '0)
               st_d = ISF_ST_ERROR;
         end
         ISF_ST_ERROR: begin
            // (R6) reset only after base block
            if (rst_go && !err_now)
               st_d = ISF_ST_NOP;
         end
         default: st_d = ISF_ST_NOP;
      endcase
   end

   // events: error entry, equality rise, chopper on; set wins over clear
   logic [`ISF_IRQ_W-1:0] ev;
   always_comb begin
      ev = {chop_d && !chop_q, eq_chk && !eq_prev_q, err_d && !err_q};
      ist_d = ist_q;
      if (wr && paddr == `ISF_ADDR_IRQ_CLR)
         ist_d = ist_q & ~pwdata[`ISF_IRQ_W-1:0];
      ist_d = ist_d | ev;
      irq_d = |(ist_d & ien_d);
   end

   always_comb begin
      // (R2) hardware release kills chopper, (R13) threshold
      chop_d = hardware_release_input && chop_perm && (dc_link_voltage > thr_q);
      // (R3) limit to rated frequency
      frq_d = flags_q[`ISF_B_DERATE] && sw_freq_above_rated;
      err_d = err_now || st_q == ISF_ST_BBLOCK || st_q == ISF_ST_ERROR;
      // (R11) equality outputs
      cr_d = eq_chk;
      tmr_d = eq_chk != eq_prev_q;
      eq_prev_d = eq_chk;
      wd_d = !wd_off;
      rel_d = rel_eff;
      case (st_q)
         ISF_ST_RUN:    disp_d = cond.search ? `ISF_DISP_SEARCH : `ISF_DISP_RUN;
         // (R5) hide base block
         ISF_ST_BBLOCK: disp_d = flags_q[`ISF_B_HIDE_BBL] ?
                                 (cond.uv ? `ISF_DISP_UV : `ISF_DISP_ERR) : `ISF_DISP_BBL;
         ISF_ST_ERROR:  disp_d = cond.uv ? `ISF_DISP_UV : `ISF_DISP_ERR;
         default:       disp_d = `ISF_DISP_NOP;
      endcase
      sw_d = '{error_bit: err_d, equal_bit: eq_chk, wd_active: !wd_off,
               sw_freq_rated: frq_d, chopper_ok: chop_perm};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= `ISF_FLAGS_RST;
         ctrl_q <= '0;
         thr_q <= '0; act_q <= '0; set_q <= '0; hys_q <= '0;
         ist_q <= '0; ien_q <= '0;
         bb_q <= '0;
         st_q <= ISF_ST_NOP;
         ready_q <= 1'b0; slverr_q <= 1'b0; rdata_q <= '0;
         chop_q <= 1'b0; frq_q <= 1'b0; err_q <= 1'b0; cr_q <= 1'b0;
         tmr_q <= 1'b0; wd_q <= 1'b1; rel_q <= 1'b0; irq_q <= 1'b0;
         disp_q <= `ISF_DISP_NOP;
         sw_q <= '0;
         eq_prev_q <= 1'b0;
      end else if (clk_en) begin
         flags_q <= flags_d;
         ctrl_q <= ctrl_d;
         thr_q <= thr_d; act_q <= act_d; set_q <= set_d; hys_q <= hys_d;
         ist_q <= ist_d; ien_q <= ien_d;
         bb_q <= bb_d;
         st_q <= st_d;
         ready_q <= ready_d; slverr_q <= slverr_d; rdata_q <= rdata_d;
         chop_q <= chop_d; frq_q <= frq_d; err_q <= err_d; cr_q <= cr_d;
         tmr_q <= tmr_d; wd_q <= wd_d; rel_q <= rel_d; irq_q <= irq_d;
         disp_q <= disp_d;
         sw_q <= sw_d;
         eq_prev_q <= eq_prev_d;
      end
   end

   assign pready = ready_q;
   assign prdata = rdata_q;
   assign pslverr = slverr_q;
   assign brake_chopper_transistor = chop_q;
   assign switch_freq_limit = frq_q;
   assign error_condition = err_q;
   assign constant_run_condition = cr_q;
   assign timer_trigger = tmr_q;
   assign watchdog_enable = wd_q;
   assign effective_release = rel_q;
   assign drive_state_display = disp_q;
   assign drive_status_word = sw_q;
   assign irq = irq_q;

   // assertions: most checks gate on clk_en high; a_freeze_state checks clk_en low
   a_chop_hw_off: assert property (@(posedge pclk) disable iff (!presetn) // (R2)
      clk_en && !hardware_release_input |=> !brake_chopper_transistor)
      else $error("chopper on with release open");
   a_chop_mod_off: assert property (@(posedge pclk) disable iff (!presetn) // (R12)
      clk_en && !modulation_on && !flags_q[`ISF_B_CHOP_NOP] && !flags_q[`ISF_B_CHOP_SWNOP]
      |=> !brake_chopper_transistor) else $error("chopper on with modulation off");
   a_chop_thresh: assert property (@(posedge pclk) disable iff (!presetn) // (R13)
      clk_en && hardware_release_input && modulation_on && dc_link_voltage > thr_q
      |=> brake_chopper_transistor) else $error("chopper not on above threshold");
   a_freq_limit: assert property (@(posedge pclk) disable iff (!presetn) // (R3)
      clk_en && flags_q[`ISF_B_DERATE] && sw_freq_above_rated |=> switch_freq_limit)
      else $error("frequency not limited");
   a_wd_disable: assert property (@(posedge pclk) disable iff (!presetn) // (R8)
      clk_en && flags_q[`ISF_B_WD_OFF] && release_disable_input |=> !watchdog_enable)
      else $error("watchdog still enabled");
   a_rel_hw_only: assert property (@(posedge pclk) disable iff (!presetn) // (R14)
      clk_en && release_disable_input |=> effective_release == $past(hardware_release_input))
      else $error("release not from hardware");
   a_bbl_hidden: assert property (@(posedge pclk) disable iff (!presetn) // (R5)
      clk_en && flags_q[`ISF_B_HIDE_BBL] |=> drive_state_display != `ISF_DISP_BBL)
      else $error("base block displayed");
   a_bb_no_reset: assert property (@(posedge pclk) disable iff (!presetn) // (R6)
      st_q == ISF_ST_BBLOCK |=> st_q != ISF_ST_NOP)
      else $error("reset during base block");
   a_eq_cont: assert property (@(posedge pclk) disable iff (!presetn) // (R10)
      clk_en && flags_q[`ISF_B_CHK_CONT] && act_q == set_q |=> constant_run_condition)
      else $error("equality check stopped");
   a_pready_one: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready) else $error("pready held");
   a_uv_masked: assert property (@(posedge pclk) disable iff (!presetn) // (R4)
      clk_en && flags_q[`ISF_B_UV_NOERR] && cond.uv && !cond.dir_ok && !cond.fault
      && !cond.warn && !cond.wd_bus && !cond.wd_time
      && (st_q == ISF_ST_NOP || st_q == ISF_ST_RUN) |=> !error_condition)
      else $error("undervoltage counted as error");
   a_warn_error: assert property (@(posedge pclk) disable iff (!presetn) // (R7)
      clk_en && flags_q[`ISF_B_WARN_ERR] && cond.warn
      |=> error_condition && drive_status_word.error_bit)
      else $error("warning not raised as error");
   a_reset_hyst: assert property (@(posedge pclk) disable iff (!presetn) // (R9)
      clk_en && st_q == ISF_ST_ERROR && flags_q[`ISF_B_RST_AT0] && !(act_mag < hys_q)
      |=> st_q != ISF_ST_NOP) else $error("reset taken at speed");
   a_wd_autoclear: assert property (@(posedge pclk) disable iff (!presetn) // (R15)
      clk_en && st_q == ISF_ST_NOP && wd_off && ctrl_q[`ISF_C_WD_AUTO] && !cond.fault
      && !cond.uv && !cond.warn |=> !error_condition)
      else $error("watchdog fault not cleared");
   a_sw_nop_chop: assert property (@(posedge pclk) disable iff (!presetn) // (R1)
      clk_en && st_q == ISF_ST_NOP && flags_q[`ISF_B_CHOP_SWNOP] && ctrl_q[`ISF_C_SW_SEL]
      && hardware_release_input && dc_link_voltage > thr_q |=> brake_chopper_transistor)
      else $error("chopper blocked in software nop");
   a_nop_chop: assert property (@(posedge pclk) disable iff (!presetn) // (R17)
      clk_en && st_q == ISF_ST_NOP && flags_q[`ISF_B_CHOP_NOP]
      && hardware_release_input && dc_link_voltage > thr_q |=> brake_chopper_transistor)
      else $error("chopper blocked in nop");
   a_eq_status: assert property (@(posedge pclk) disable iff (!presetn) // (R11)
      clk_en && flags_q[`ISF_B_CHK_CONT] && act_q == set_q |=> drive_status_word.equal_bit)
      else $error("equality missing in status");
   a_eq_trigger: assert property (@(posedge pclk) disable iff (!presetn) // (R11)
      clk_en && eq_chk != eq_prev_q |=> timer_trigger)
      else $error("timer trigger missing");
   a_bbl_shown: assert property (@(posedge pclk) disable iff (!presetn) // (R5)
      clk_en && st_q == ISF_ST_BBLOCK && !flags_q[`ISF_B_HIDE_BBL]
      |=> drive_state_display == `ISF_DISP_BBL) else $error("base block not shown");
   a_bb_hold: assert property (@(posedge pclk) disable iff (!presetn) // (R6)
      clk_en && st_q == ISF_ST_BBLOCK && bb_q != '0 |=> st_q == ISF_ST_BBLOCK)
      else $error("base block left early");
   a_freeze_state: assert property (@(posedge pclk) disable iff (!presetn)
      !clk_en |=> $stable(st_q) && $stable(flags_q) && $stable(switch_freq_limit))
      else $error("state moved while frozen");
   a_flags_store: assert property (@(posedge pclk) disable iff (!presetn) // (R18)
      clk_en && psel && penable && pwrite && !pready && paddr == `ISF_ADDR_FLAGS
      |=> flags_q == $past(pwdata[14:0])) else $error("flags not stored");
   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      irq == |(ist_q & ien_q)) else $error("irq level wrong");
   a_slverr_pair: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready) else $error("slave error without ready");
   a_derate_off: assert property (@(posedge pclk) disable iff (!presetn) // (R3)
      clk_en && !flags_q[`ISF_B_DERATE] |=> !switch_freq_limit)
      else $error("frequency limited without flag");
   // covers: hidden base block, equality with modulation off, chopper in no-operation, error reset, irq
   c_bbl_hidden: cover property (@(posedge pclk) disable iff (!presetn)
      st_q == ISF_ST_BBLOCK && flags_q[`ISF_B_HIDE_BBL]);
   c_eq_modoff: cover property (@(posedge pclk) disable iff (!presetn)
      constant_run_condition && !modulation_on);
   c_chop_nop: cover property (@(posedge pclk) disable iff (!presetn)
      st_q == ISF_ST_NOP && brake_chopper_transistor);
   c_err_reset: cover property (@(posedge pclk) disable iff (!presetn)
      st_q == ISF_ST_ERROR ##1 st_q == ISF_ST_NOP);
   c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule

// ### inc/isf_params.svh
`ifndef ISF_PARAMS_SVH
`define ISF_PARAMS_SVH
// register byte addresses
`define ISF_ADDR_FLAGS     12'h000
`define ISF_ADDR_CTRL      12'h004
`define ISF_ADDR_STATUS    12'h008
`define ISF_ADDR_IRQ_STAT  12'h00C
`define ISF_ADDR_IRQ_EN    12'h010
`define ISF_ADDR_IRQ_CLR   12'h014
`define ISF_ADDR_THRESH    12'h018
`define ISF_ADDR_ACTUAL    12'h01C
`define ISF_ADDR_SETVAL    12'h020
`define ISF_ADDR_HYST      12'h024
// flag bit positions
`define ISF_B_CHOP_NOP     0
`define ISF_B_CHOP_SWNOP   5
`define ISF_B_DERATE       6
`define ISF_B_UV_NOERR     7
`define ISF_B_HIDE_BBL     8
`define ISF_B_WARN_ERR     10
`define ISF_B_WD_OFF       11
`define ISF_B_RST_AT0      12
`define ISF_B_CHK_CONT     13
// control register bits
`define ISF_C_SW_REL       0
`define ISF_C_SW_SEL       1
`define ISF_C_RST_REQ      2
`define ISF_C_WD_AUTO      3
// reset values and display codes
`define ISF_FLAGS_RST      15'h0000
`define ISF_DISP_NOP       8'h00
`define ISF_DISP_RUN       8'h01
`define ISF_DISP_UV        8'h02
`define ISF_DISP_SEARCH    8'h4A
`define ISF_DISP_BBL       8'h4C
`define ISF_DISP_ERR       8'h10
// base-block time and interrupt width
`define ISF_BB_TIME_US     500
`define ISF_CLK_MHZ        20
`define ISF_IRQ_W          3
`endif

// ### inc/isf_pkg.sv
package isf_pkg;
   typedef enum logic [1:0] {ISF_ST_NOP, ISF_ST_RUN, ISF_ST_BBLOCK, ISF_ST_ERROR} isf_state_e;
   typedef struct packed {
      logic uv;
      logic warn;
      logic fault;
      logic wd_bus;
      logic wd_time;
      logic dir_ok;
      logic search;
   } isf_cond_s;
   typedef struct packed {
      logic error_bit;
      logic equal_bit;
      logic wd_active;
      logic sw_freq_rated;
      logic chopper_ok;
   } isf_stat_s;
endpackage
